// *** logic/osd_map.svh ***
// register offsets, field positions and reset values of the octal sink driver
// assumes: included by bare name from the package and from the top module
`ifndef OSD_MAP_SVH
`define OSD_MAP_SVH

// channel count and widths
`define OSD_CH 8
`define OSD_AW 12
`define OSD_CNT_W 8

// register byte offsets on the apb side
`define OSD_OFF_CTRL 12'h000
`define OSD_OFF_STAT 12'h004
`define OSD_OFF_SHAD 12'h008
`define OSD_OFF_TRIP 12'h00C

// field positions
`define OSD_CTRL_FORCE_OFF 0
`define OSD_STAT_DRV 0
`define OSD_STAT_OC 8
`define OSD_STAT_FAULT 16
`define OSD_STAT_OT 17
`define OSD_STAT_GATE 18
`define OSD_STAT_STB 19
`define OSD_SHAD_MIR 0
`define OSD_SHAD_BUF 8
`define OSD_TRIP_CNT 0
`define OSD_WSTRB_LO 0

// constants and reset values
`define OSD_ZERO8 8'h00
`define OSD_ZERO32 32'h0000_0000
`define OSD_CNT_MAX 8'hFF
`define OSD_CNT_ONE 8'h01

`endif

// *** logic/osd_pkg.sv ***
// state types shared by the octal sink driver modules
// assumes: osd_map.svh is reachable on the include path
`default_nettype none
`include "osd_map.svh"

package osd_pkg;

    typedef logic [`OSD_CH-1:0] osd_chan_t;

    // serial-clock domain state
    typedef struct packed {
        osd_chan_t shift;
        logic tog;
    } osd_shift_s;

    // pclk domain state
    typedef struct packed {
        logic [1:0] stb_sy;
        logic [1:0] gate_sy;
        logic [1:0] ot_sy;
        logic [1:0] tog_sy;
        logic [1:0][`OSD_CH-1:0] oc_sy;
        logic stb_d;
        logic tog_d;
        osd_chan_t mirror;
        osd_chan_t buffer;
        osd_chan_t oc_latch;
        osd_chan_t drive;
        logic fault;
        logic force_off;
        logic [`OSD_CNT_W-1:0] trips;
        logic answered;
        logic [31:0] rdata;
        logic slverr;
    } osd_core_s;

endpackage : osd_pkg

`default_nettype wire

// *** logic/osd_link_if.sv ***
// carries the shift register word and its change toggle out of the serial clock domain
// assumes: word only changes together with tog, at a serial clock rising edge
`timescale 1ns/1ps
`default_nettype none

interface osd_link_if
    import osd_pkg::*;
();
    osd_chan_t word;
    logic tog;

    modport src (output word, output tog);
    modport dst (input word, input tog);
endinterface : osd_link_if

`default_nettype wire

// *** logic/osd_shift.sv ***
// eight-stage input shift register clocked by the serial link clock
// assumes: serial_data_in is set up to serial_clk; presetn asserts asynchronously
`timescale 1ns/1ps
`default_nettype none

module osd_shift
    import osd_pkg::*;
(
    input wire logic serial_clk,
    input wire logic presetn,
    input wire logic serial_data_in,
    output logic cascade_out,
    osd_link_if.src lnk
);

    osd_shift_s r_reg;
    osd_shift_s r_next;

    // shift in at bit 0, so the first bit ends up at the top stage
    always_comb begin
        r_next = r_reg;
        r_next.shift = {r_reg.shift[`OSD_CH-2:0], serial_data_in};
        r_next.tog = ~r_reg.tog;
    end

    // the link clock may stop between frames; nothing here needs a trailing edge
    always_ff @(posedge serial_clk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // word and toggle leave together from the same flops
    assign lnk.word = r_reg.shift;
    assign lnk.tog = r_reg.tog;
    assign cascade_out = r_reg.shift[`OSD_CH-1];

    property p_shift_in;
        @(posedge serial_clk) disable iff (!presetn)
        ##1 r_reg.shift[`OSD_CH-1:1] == $past(r_reg.shift[`OSD_CH-2:0]);
    endproperty
    a_shift_in: assert property (p_shift_in)
        else $error("shift register did not advance by one stage");

    property p_cascade;
        @(posedge serial_clk) disable iff (!presetn)
        ##1 cascade_out == $past(r_reg.shift[`OSD_CH-2]);
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("cascade output is not the bit leaving the register");

endmodule : osd_shift

`default_nettype wire

// *** logic/osd_top.sv ***
// control logic of the octal low-side sink driver with serial loading and apb status
// assumes: serial_clk is the link clock, unrelated to pclk and slower than pclk / 3;
// transfer_pulse, drive_gate_n and the trip inputs are asynchronous pins
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "osd_map.svh"

module osd_top
    import osd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic [`OSD_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic transfer_pulse,
    input wire logic drive_gate_n,
    input wire logic [`OSD_CH-1:0] overcurrent_trip,
    input wire logic overheat_shutdown,
    output logic cascade_out,
    output logic [`OSD_CH-1:0] power_sink_outputs,
    output logic overcurrent_fault_n
);

    osd_core_s r_reg;
    osd_core_s r_next;

    osd_link_if lnk ();

    // serial clock domain lives in its own module
    osd_shift u_shift (
        .serial_clk(serial_clk),
        .presetn(presetn),
        .serial_data_in(serial_data_in),
        .cascade_out(cascade_out),
        .lnk(lnk.src)
    );

    // mapped register test, used for the error answer of reads and writes
    function automatic logic osd_hit(input logic [`OSD_AW-1:0] a);
        return (a == `OSD_OFF_CTRL) || (a == `OSD_OFF_STAT) ||
               (a == `OSD_OFF_SHAD) || (a == `OSD_OFF_TRIP);
    endfunction : osd_hit

    // top stage holds the first shifted bit; flip it so channel 0 gets that bit
    function automatic osd_chan_t osd_rev(input osd_chan_t w);
        osd_chan_t v;
        v = '0;
        for (int i = 0; i < `OSD_CH; i++) begin
            v[i] = w[`OSD_CH-1-i];
        end
        return v;
    endfunction : osd_rev

    // read word for an address; unmapped reads return zero
    function automatic logic [31:0] osd_rd(input logic [`OSD_AW-1:0] a, input osd_core_s s);
        logic [31:0] w;
        w = `OSD_ZERO32;
        if (a == `OSD_OFF_CTRL) begin
            w[`OSD_CTRL_FORCE_OFF] = s.force_off;
        end else if (a == `OSD_OFF_STAT) begin
            w[`OSD_STAT_DRV +: `OSD_CH] = s.drive;
            w[`OSD_STAT_OC +: `OSD_CH] = s.oc_latch;
            w[`OSD_STAT_FAULT] = s.fault;
            w[`OSD_STAT_OT] = s.ot_sy[1];
            w[`OSD_STAT_GATE] = s.gate_sy[1];
            w[`OSD_STAT_STB] = s.stb_sy[1];
        end else if (a == `OSD_OFF_SHAD) begin
            w[`OSD_SHAD_MIR +: `OSD_CH] = s.mirror;
            w[`OSD_SHAD_BUF +: `OSD_CH] = s.buffer;
        end else if (a == `OSD_OFF_TRIP) begin
            w[`OSD_TRIP_CNT +: `OSD_CNT_W] = s.trips;
        end
        return w;
    endfunction : osd_rd

    // decoded strobe, toggle and trip events
    logic stb_s;
    logic stb_rise;
    logic word_new;
    logic all_off;
    logic apb_done;
    logic wr_ctrl;
    logic wr_trip;
    osd_chan_t trip_set;
    osd_chan_t latch_next;

    always_comb begin
        stb_s = r_reg.stb_sy[1];
        stb_rise = stb_s & ~r_reg.stb_d;
        // toggle moved: the word has been stable for the two synchroniser cycles before we look
        word_new = r_reg.tog_sy[1] ^ r_reg.tog_d;
        // global off: gate high, overheating or software force
        all_off = r_reg.gate_sy[1] | r_reg.ot_sy[1] | r_reg.force_off;
        // only a channel that is set in the buffer can trip
        trip_set = r_reg.oc_sy[1] & r_reg.buffer;
        // a trip in the same cycle as the clearing pulse is kept
        latch_next = (stb_rise ? `OSD_ZERO8 : r_reg.oc_latch) | trip_set;
        apb_done = psel & penable & r_reg.answered;
        wr_ctrl = apb_done & pwrite & (paddr == `OSD_OFF_CTRL) & pstrb[`OSD_WSTRB_LO];
        wr_trip = apb_done & pwrite & (paddr == `OSD_OFF_TRIP) & pstrb[`OSD_WSTRB_LO];
    end

    // next-state logic for the whole pclk domain
    always_comb begin
        r_next = r_reg;

        // two-flop synchronisers; only stage 1 is read by logic
        r_next.stb_sy = {r_reg.stb_sy[0], transfer_pulse};
        r_next.gate_sy = {r_reg.gate_sy[0], drive_gate_n};
        r_next.ot_sy = {r_reg.ot_sy[0], overheat_shutdown};
        r_next.tog_sy = {r_reg.tog_sy[0], lnk.tog};
        r_next.oc_sy = {r_reg.oc_sy[0], overcurrent_trip};
        r_next.stb_d = stb_s;
        r_next.tog_d = r_reg.tog_sy[1];

        // mirror of the shift register, captured only after the toggle says it is settled
        if (word_new) begin
            r_next.mirror = osd_rev(lnk.word);
        end

        // buffer is transparent while the pulse is high, then holds
        if (stb_s) begin
            r_next.buffer = r_reg.mirror;
        end

        // per-channel over-current latches and the shared fault flag
        r_next.oc_latch = latch_next;
        r_next.fault = |latch_next;

        // drive follows the buffer, masked by trips and the global off
        r_next.drive = r_reg.buffer & ~latch_next & {`OSD_CH{~all_off}};

        // count fresh trips; clearing by software loses no event of the same cycle
        if (wr_trip) begin
            r_next.trips = (|(trip_set & ~r_reg.oc_latch)) ? `OSD_CNT_ONE : '0;
        end else if ((|(trip_set & ~r_reg.oc_latch)) && (r_reg.trips != `OSD_CNT_MAX)) begin
            r_next.trips = r_reg.trips + `OSD_CNT_ONE;
        end

        // software force-off switch
        if (wr_ctrl) begin
            r_next.force_off = pwdata[`OSD_CTRL_FORCE_OFF];
        end

        // apb: capture the answer once per transfer, release at completion
        if (apb_done) begin
            r_next.answered = 1'b0;
        end else if (psel && !r_reg.answered) begin
            r_next.answered = 1'b1;
            r_next.rdata = pwrite ? `OSD_ZERO32 : osd_rd(paddr, r_reg);
            r_next.slverr = ~osd_hit(paddr);
        end
    end

    // all pclk-domain state frozen while clk_en is low; reset clears every driver
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    // outputs straight from flops, except the apb handshake
    assign pready = psel & penable & r_reg.answered & clk_en;
    assign prdata = r_reg.rdata;
    assign pslverr = r_reg.slverr;
    assign power_sink_outputs = r_reg.drive;
    assign overcurrent_fault_n = ~r_reg.fault;

    // the serial bit order must match the channel order of the buffer
    // the chain behaviour of the controller is taken on trust here

    property p_transfer;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && r_reg.stb_sy[1]) |=> (r_reg.buffer == $past(r_reg.mirror));
    endproperty
    a_transfer: assert property (p_transfer)
        else $error("buffer did not follow the shift register during the pulse");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        (!r_reg.stb_sy[1]) |=> (r_reg.buffer == $past(r_reg.buffer));
    endproperty
    a_hold: assert property (p_hold)
        else $error("buffer changed while the pulse was low");

    property p_trip_off;
        @(posedge pclk) disable iff (!presetn)
        (r_reg.drive & r_reg.oc_latch) == `OSD_ZERO8;
    endproperty
    a_trip_off: assert property (p_trip_off)
        else $error("a tripped channel is still driven");

    property p_fault_src;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && r_reg.ot_sy[1] && (r_reg.oc_latch == `OSD_ZERO8) &&
         (r_reg.oc_sy[1] == `OSD_ZERO8)) |=> overcurrent_fault_n;
    endproperty
    a_fault_src: assert property (p_fault_src)
        else $error("fault flag asserted without an over-current trip");

    property p_fault_hold;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !overcurrent_fault_n && !(r_reg.stb_sy[1] && !r_reg.stb_d))
        |=> !overcurrent_fault_n;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault flag released without a transfer pulse");

    property p_gate;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && r_reg.gate_sy[1]) |=> (power_sink_outputs == `OSD_ZERO8);
    endproperty
    a_gate: assert property (p_gate)
        else $error("outputs driven while the gate input is high");

    property p_follow;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && !r_reg.gate_sy[1] && !r_reg.ot_sy[1] && !r_reg.force_off &&
         (r_reg.oc_sy[1] == `OSD_ZERO8) && !(r_reg.stb_sy[1] && !r_reg.stb_d))
        |=> (power_sink_outputs == ($past(r_reg.buffer) & ~$past(r_reg.oc_latch)));
    endproperty
    a_follow: assert property (p_follow)
        else $error("enabled outputs do not follow the buffer");

    property p_overheat;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && r_reg.ot_sy[1]) |=> (power_sink_outputs == `OSD_ZERO8);
    endproperty
    a_overheat: assert property (p_overheat)
        else $error("outputs on during overheat shutdown");

    property p_apb_once;
        @(posedge pclk) disable iff (!presetn)
        (pready) |=> !pready;
    endproperty
    a_apb_once: assert property (p_apb_once)
        else $error("ready held for two cycles in a row");

    property p_fault_clear;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && stb_rise && (r_reg.oc_sy[1] == `OSD_ZERO8)) |=> overcurrent_fault_n;
    endproperty
    a_fault_clear: assert property (p_fault_clear)
        else $error("fault flag not cleared by the transfer pulse");

    property p_force_off;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && r_reg.force_off) |=> (power_sink_outputs == `OSD_ZERO8);
    endproperty
    a_force_off: assert property (p_force_off)
        else $error("outputs on while software force-off is set");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (pready && !osd_hit(paddr)) |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access answered without an error");

    property p_trip_clear;
        @(posedge pclk) disable iff (!presetn)
        (clk_en && wr_trip && (r_reg.oc_sy[1] == `OSD_ZERO8)) |=> (r_reg.trips == `OSD_ZERO8);
    endproperty
    a_trip_clear: assert property (p_trip_clear)
        else $error("trip counter not cleared by a write");

endmodule : osd_top

`default_nettype wire

// *** bench/osd_ctl_model.sv ***
// serial controller model: shifts words into the driver and strobes them
// assumes: the driver samples serial_data_in on rising serial_clk
`timescale 1ns/1ps
`default_nettype none

module osd_ctl_model (
    output logic serial_clk,
    output logic serial_data_in,
    output logic transfer_pulse
);
    // idle: clock parked low outside frames
    initial begin
        serial_clk = 1'b0;
        serial_data_in = 1'b0;
        transfer_pulse = 1'b0;
    end

    // first bit first, 160 ns per bit; odd offset keeps edges off pclk
    task automatic send8(input logic [7:0] w);
        #7;
        for (int i = 0; i < 8; i++) begin
            serial_data_in = w[i];
            #80 serial_clk = 1'b1;
            #80 serial_clk = 1'b0;
        end
        // hold time over: line stops showing the last bit
        serial_data_in = ~serial_data_in;
    endtask : send8

    // one pulse after all chained bits, long enough for pclk to see it
    task automatic strobe();
        #100 transfer_pulse = 1'b1;
        #300 transfer_pulse = 1'b0;
        #100;
    endtask : strobe
endmodule : osd_ctl_model

`default_nettype wire

// *** bench/osd_tb_top.sv ***
// self-checking bench for the octal sink driver control block
// assumes: package, link interface, design modules and controller model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "osd_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module octal_serial_sink_driver_control_tb_top;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
    logic serial_clk, serial_data_in, transfer_pulse, drive_gate_n;
    logic overheat_shutdown, cascade_out, overcurrent_fault_n;
    logic [`OSD_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [`OSD_CH-1:0] overcurrent_trip, power_sink_outputs;
    int mismatches = 0;
    int checked = 0;

    osd_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .serial_clk(serial_clk),
        .serial_data_in(serial_data_in), .transfer_pulse(transfer_pulse),
        .drive_gate_n(drive_gate_n), .overcurrent_trip(overcurrent_trip),
        .overheat_shutdown(overheat_shutdown), .cascade_out(cascade_out),
        .power_sink_outputs(power_sink_outputs), .overcurrent_fault_n(overcurrent_fault_n));
    osd_ctl_model ctl_u (.serial_clk(serial_clk), .serial_data_in(serial_data_in),
        .transfer_pulse(transfer_pulse));

    // 50 MHz system clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    // one apb transfer; no wait-state count assumed, bounded wait for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // outputs pass through synchronisers, so allow a bounded settle
    task automatic wait_out(input logic [7:0] e);
        int n;
        n = 0;
        while (power_sink_outputs !== e && n < 40) begin
            @(posedge pclk);
            n++;
        end
        `CHK(power_sink_outputs, e)
        if (power_sink_outputs !== e) test_done();
    endtask : wait_out

    task automatic t_reset();
        `CHK({cascade_out, overcurrent_fault_n, power_sink_outputs}, 10'h100)
        apb(1'b0, `OSD_OFF_CTRL, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        $display("test reset done");
    endtask : t_reset

    task automatic t_load();
        ctl_u.send8(8'h0B);
        `CHK(power_sink_outputs, 8'h00)
        `CHK(cascade_out, 1'b1)
        ctl_u.strobe();
        wait_out(8'h0B);
        ctl_u.send8(8'h50);
        repeat (20) @(posedge pclk);
        `CHK(power_sink_outputs, 8'h0B)
        ctl_u.send8(8'hA5);
        `CHK(cascade_out, 1'b1)
        ctl_u.send8(8'h3C);
        `CHK(cascade_out, 1'b0)
        ctl_u.strobe();
        wait_out(8'h3C);
        apb(1'b0, `OSD_OFF_SHAD, 32'h0000_0000);
        `CHK(rd, 32'h0000_3C3C)
        $display("test load done");
    endtask : t_load

    task automatic t_gate_regs();
        ctl_u.send8(8'hFF);
        ctl_u.strobe();
        wait_out(8'hFF);
        @(posedge pclk) drive_gate_n <= 1'b1;
        wait_out(8'h00);
        @(posedge pclk) drive_gate_n <= 1'b0;
        wait_out(8'hFF);
        // clock enable low freezes the outputs even when the gate rises
        @(posedge pclk);
        clk_en <= 1'b0;
        drive_gate_n <= 1'b1;
        repeat (10) @(posedge pclk);
        `CHK(power_sink_outputs, 8'hFF)
        clk_en <= 1'b1;
        drive_gate_n <= 1'b0;
        wait_out(8'hFF);
        apb(1'b1, `OSD_OFF_CTRL, 32'h0000_0001);
        wait_out(8'h00);
        apb(1'b0, `OSD_OFF_CTRL, 32'h0000_0000);
        `CHK(rd, 32'h0000_0001)
        apb(1'b1, `OSD_OFF_CTRL, 32'h0000_0000);
        wait_out(8'hFF);
        apb(1'b0, `OSD_OFF_STAT, 32'h0000_0000);
        `CHK(rd[7:0], 8'hFF)
        // unmapped word must be refused
        apb(1'b0, 12'h010, 32'h0000_0000);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
        $display("test gate and registers done");
    endtask : t_gate_regs

    task automatic t_trip();
        @(posedge pclk) overcurrent_trip <= 8'h04;
        wait_out(8'hFB);
        `CHK(overcurrent_fault_n, 1'b0)
        @(posedge pclk) overcurrent_trip <= 8'h00;
        repeat (20) @(posedge pclk);
        `CHK({overcurrent_fault_n, power_sink_outputs}, 9'h0FB)
        apb(1'b0, `OSD_OFF_TRIP, 32'h0000_0000);
        `CHK(rd, 32'h0000_0001)
        apb(1'b1, `OSD_OFF_TRIP, 32'h0000_0000);
        apb(1'b0, `OSD_OFF_TRIP, 32'h0000_0000);
        `CHK(rd, 32'h0000_0000)
        ctl_u.strobe();
        wait_out(8'hFF);
        `CHK(overcurrent_fault_n, 1'b1)
        @(posedge pclk) overheat_shutdown <= 1'b1;
        wait_out(8'h00);
        `CHK(overcurrent_fault_n, 1'b1)
        @(posedge pclk) overheat_shutdown <= 1'b0;
        wait_out(8'hFF);
        // reset again in mid-run with all channels on
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK(power_sink_outputs, 8'h00)
        @(posedge pclk) presetn <= 1'b1;
        $display("test trip done");
    endtask : t_trip

    // main sequence
    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hF;
        drive_gate_n = 1'b0;
        overcurrent_trip = 8'h00;
        overheat_shutdown = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_load();
        t_gate_regs();
        t_trip();
        test_done();
    end
endmodule : octal_serial_sink_driver_control_tb_top

`default_nettype wire
